//--- design/ocr_params.svh
// constants of the octal converter serial readout block
// Contract
// - strobe high holds acquisition; host keeps it high for the acquisition interval.
// - strobe falling edge converts all eight channels and loads results for shifting.
// - single rate: every output advances one bit only on serial clock falling edges.
// - double rate: every output advances one bit on both serial clock edges.
// - echo clock output is a slightly delayed copy of the serial clock.
// - io standard strap: low CMOS, supply LVDS, floating low-power LVDS.
// - strobe behaviour is independent of the io standard strap.
// - eight CMOS outputs; output N carries channel N first, MSB first.
// - further clocking shifts higher channels ascending, wrapping eight to one.
// - echo disable strap high turns echo clock off; ground it when used.
// - grounded reference buffer strap disables the four reference buffers.
// - each 16-bit result is two's complement.
// - outputs float after strobe rises and drive valid data after it falls; the lanes here drive only with the io strap at CMOS.
`ifndef OCR_PARAMS_SVH
`define OCR_PARAMS_SVH

`define OCR_NUM_CH 8
`define OCR_RES_BITS 16
`define OCR_CNT_BITS 7
`define OCR_CH_RESET 16'h0000

// register byte offsets
`define OCR_OFF_CH_FIRST 8'h00
`define OCR_OFF_CH_LAST 8'h1C
`define OCR_OFF_STATUS 8'h20
`define OCR_OFF_CONV_COUNT 8'h24

// status field positions
`define OCR_ST_CONVERTING 0
`define OCR_ST_DDR 1
`define OCR_ST_ECHO_OFF 2
`define OCR_ST_REFBUF 3
`define OCR_ST_IO_LSB 4
`define OCR_ST_CNT_LSB 8

`define OCR_COUNT_RESET 32'h0000_0000

`endif

//--- design/ocr_pkg.sv
// types shared by the octal converter serial readout block
package ocr_pkg;

  typedef enum logic [1:0] {
    OCR_IO_CMOS,
    OCR_IO_LVDS,
    OCR_IO_LVDS_LP
  } ocr_io_mode_t;

  typedef enum logic [1:0] {
    OCR_ACQUIRE,
    OCR_LOAD,
    OCR_SHIFT
  } ocr_state_t;

  typedef struct packed {
    logic rate_ddr;
    logic echo_off;
    logic ref_buf_on;
    ocr_io_mode_t io_mode;
  } ocr_straps_t;

  typedef logic [7:0][15:0] ocr_frame_t;

  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } ocr_apb_req_t;

endpackage : ocr_pkg

//--- design/ocr_result_mem.sv
// result word store with a registered word read port and a registered full-frame snapshot
`timescale 1ns/100ps
`include "ocr_params.svh"
module ocr_result_mem #(
  parameter int NUM_CH = `OCR_NUM_CH,
  parameter int RES_BITS = `OCR_RES_BITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [2:0] wr_addr,
  input wire logic [RES_BITS-1:0] wr_data,
  input wire logic [2:0] rd_addr,
  output logic [RES_BITS-1:0] rd_data_reg,
  input wire logic snap_en,
  output logic [NUM_CH-1:0][RES_BITS-1:0] frame_reg
);
  logic [NUM_CH-1:0][RES_BITS-1:0] mem_reg;
  logic [NUM_CH-1:0][RES_BITS-1:0] mem_next;
  logic [RES_BITS-1:0] rd_data_next;
  logic [NUM_CH-1:0][RES_BITS-1:0] frame_next;

  always_comb begin
    mem_next = mem_reg;
    if (wr_en) begin
      mem_next[wr_addr] = wr_data;
    end
    rd_data_next = mem_reg[rd_addr];
    // the snapshot freezes the words for the whole readout, so later writes cannot tear it
    frame_next = snap_en ? mem_reg : frame_reg;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mem_reg <= '0;
      rd_data_reg <= '0;
      frame_reg <= '0;
    end else if (ce) begin
      mem_reg <= mem_next;
      rd_data_reg <= rd_data_next;
      frame_reg <= frame_next;
    end
  end
endmodule : ocr_result_mem

//--- design/ocr_readout.sv
// octal converter serial readout: strobe and serial clock handling, eight CMOS lanes, APB slave
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/100ps
`include "ocr_params.svh"
module ocr_readout #(
  parameter int NUM_CH = `OCR_NUM_CH,
  parameter int RES_BITS = `OCR_RES_BITS,
  parameter int CNT_BITS = `OCR_CNT_BITS
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CONVERT_STROBE_N,
  input wire logic SERIAL_CLOCK,
  input wire logic RATE_SELECT_STRAP,
  input wire logic ECHO_CLOCK_DISABLE_STRAP,
  input wire logic [1:0] IO_STANDARD_STRAP,
  input wire logic REF_BUFFER_ENABLE_STRAP,
  output logic [7:0] SERIAL_DATA_OUTPUTS,
  output logic [7:0] SERIAL_DATA_OE,
  output logic ECHO_CLOCK_OUT,
  output logic REF_BUFFER_ON
);
  import ocr_pkg::*;

  // io strap code: bit0 tied to supply, bit1 sensed floating
  function automatic ocr_io_mode_t decode_io(input logic [1:0] code);
    ocr_io_mode_t m;
    m = OCR_IO_CMOS;
    case (code)
      2'h0: m = OCR_IO_CMOS;
      2'h1: m = OCR_IO_LVDS;
      default: m = OCR_IO_LVDS_LP;
    endcase
    return m;
  endfunction : decode_io

  function automatic logic is_ch_addr(input logic [7:0] a);
    // the word store starts at offset zero, so only the upper bound needs a compare
    return (a <= `OCR_OFF_CH_LAST) && (a[1:0] == 2'h0);
  endfunction : is_ch_addr

  function automatic logic is_mapped(input logic [7:0] a);
    return is_ch_addr(a) || (a == `OCR_OFF_STATUS) || (a == `OCR_OFF_CONV_COUNT);
  endfunction : is_mapped

  // lane n at count k shows channel n+k/16 (wrapping) bit 15-k%16
  function automatic logic lane_bit(input ocr_frame_t f, input logic [2:0] lane, input logic [CNT_BITS-1:0] k);
    logic [2:0] ch;
    logic [3:0] bitpos;
    ch = lane + k[6:4];
    bitpos = ~k[3:0];
    return f[ch][bitpos];
  endfunction : lane_bit

  // pin synchronisers
  logic [2:0] cnv_sync_reg;
  logic [2:0] cnv_sync_next;
  logic [2:0] sck_sync_reg;
  logic [2:0] sck_sync_next;
  logic [1:0] ddr_sync_reg;
  logic [1:0] echo_off_sync_reg;
  logic [1:0] refbuf_sync_reg;
  logic [1:0][1:0] io_sync_reg;
  logic [1:0] ddr_sync_next;
  logic [1:0] echo_off_sync_next;
  logic [1:0] refbuf_sync_next;
  logic [1:0][1:0] io_sync_next;

  always_comb begin
    cnv_sync_next = {cnv_sync_reg[1:0], CONVERT_STROBE_N};
    sck_sync_next = {sck_sync_reg[1:0], SERIAL_CLOCK};
    ddr_sync_next = {ddr_sync_reg[0], RATE_SELECT_STRAP};
    echo_off_sync_next = {echo_off_sync_reg[0], ECHO_CLOCK_DISABLE_STRAP};
    refbuf_sync_next = {refbuf_sync_reg[0], REF_BUFFER_ENABLE_STRAP};
    io_sync_next = {io_sync_reg[0], IO_STANDARD_STRAP};
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      cnv_sync_reg <= 3'h7;
      sck_sync_reg <= 3'h0;
      ddr_sync_reg <= 2'h0;
      echo_off_sync_reg <= 2'h0;
      refbuf_sync_reg <= 2'h3;
      io_sync_reg <= '0;
    end else if (CE) begin
      cnv_sync_reg <= cnv_sync_next;
      sck_sync_reg <= sck_sync_next;
      ddr_sync_reg <= ddr_sync_next;
      echo_off_sync_reg <= echo_off_sync_next;
      refbuf_sync_reg <= refbuf_sync_next;
      io_sync_reg <= io_sync_next;
    end
  end

  ocr_straps_t straps;
  logic cnv_fall;
  logic cnv_rise;
  logic sck_fall;
  logic sck_rise;
  logic shift_edge;

  always_comb begin
    straps.rate_ddr = ddr_sync_reg[1];
    straps.echo_off = echo_off_sync_reg[1];
    straps.ref_buf_on = refbuf_sync_reg[1];
    straps.io_mode = decode_io(io_sync_reg[1]);
    // strobe edges are taken whatever the io strap says
    cnv_fall = cnv_sync_reg[2] & ~cnv_sync_reg[1];
    cnv_rise = ~cnv_sync_reg[2] & cnv_sync_reg[1];
    sck_fall = sck_sync_reg[2] & ~sck_sync_reg[1];
    sck_rise = ~sck_sync_reg[2] & sck_sync_reg[1];
    shift_edge = sck_fall | (straps.rate_ddr & sck_rise);
  end

  // result store
  ocr_apb_req_t req;
  logic access_cycle;
  logic ack_reg;
  logic ack_next;
  logic wr_fire;
  logic [RES_BITS-1:0] mem_rd_data;
  ocr_frame_t frame;
  logic snap;

  always_comb begin
    req.sel = PSEL;
    req.enable = PENABLE;
    req.write = PWRITE;
    req.addr = PADDR;
    req.wdata = PWDATA;
    access_cycle = req.sel & req.enable;
    wr_fire = access_cycle & ack_reg & req.write & is_ch_addr(req.addr) & CE;
  end

  ocr_result_mem #(
    .NUM_CH(NUM_CH),
    .RES_BITS(RES_BITS)
  ) u_mem (
    .clk(REF_CLK),
    .rst(RST),
    .ce(CE),
    .wr_en(wr_fire),
    .wr_addr(req.addr[4:2]),
    .wr_data(req.wdata[RES_BITS-1:0]),
    .rd_addr(req.addr[4:2]),
    .rd_data_reg(mem_rd_data),
    .snap_en(snap),
    .frame_reg(frame)
  );

  // conversion and shift sequencing
  ocr_state_t state_reg;
  ocr_state_t state_next;
  logic [CNT_BITS-1:0] cnt_reg;
  logic [CNT_BITS-1:0] cnt_next;
  logic [31:0] conv_count_reg;
  logic [31:0] conv_count_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    conv_count_next = conv_count_reg;
    snap = 1'b0;
    case (state_reg)
      OCR_ACQUIRE: begin
        // strobe high: acquisition, outputs released
        if (cnv_fall) begin
          snap = 1'b1;
          conv_count_next = conv_count_reg + 32'h0000_0001;
          state_next = OCR_LOAD;
        end
      end
      OCR_LOAD: begin
        cnt_next = '0;
        state_next = cnv_rise ? OCR_ACQUIRE : OCR_SHIFT;
      end
      OCR_SHIFT: begin
        if (cnv_rise) begin
          state_next = OCR_ACQUIRE;
        end else if (shift_edge) begin
          // past 128 bits the count wraps and the lanes repeat their rotation
          cnt_next = cnt_reg + {{(CNT_BITS-1){1'b0}}, 1'b1};
        end
      end
      default: begin
        state_next = OCR_ACQUIRE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_reg <= OCR_ACQUIRE;
      cnt_reg <= '0;
      conv_count_reg <= `OCR_COUNT_RESET;
    end else if (CE) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      conv_count_reg <= conv_count_next;
    end
  end

  // lane outputs and echo clock
  logic [7:0] sdo_reg;
  logic [7:0] sdo_next;
  logic [7:0] oe_reg;
  logic [7:0] oe_next;
  logic echo_reg;
  logic echo_next;
  logic refbuf_reg;
  logic refbuf_next;
  logic drive_lanes;

  always_comb begin
    // lanes wait out the load cycle, so the first bit shown already comes from the new snapshot
    drive_lanes = (state_next == OCR_SHIFT) && (straps.io_mode == OCR_IO_CMOS);
    oe_next = {8{drive_lanes}};
    // one cycle behind the edge: the echo clock below carries the same delay, keeping skew matched
    echo_next = sck_sync_reg[1] & ~straps.echo_off;
    refbuf_next = straps.ref_buf_on;
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_lane
      always_comb begin
        sdo_next[g] = drive_lanes ? lane_bit(frame, 3'(g), cnt_next) : 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      sdo_reg <= 8'h00;
      oe_reg <= 8'h00;
      echo_reg <= 1'b0;
      refbuf_reg <= 1'b1;
    end else if (CE) begin
      sdo_reg <= sdo_next;
      oe_reg <= oe_next;
      echo_reg <= echo_next;
      refbuf_reg <= refbuf_next;
    end
  end

  assign SERIAL_DATA_OUTPUTS = sdo_reg;
  assign SERIAL_DATA_OE = oe_reg;
  assign ECHO_CLOCK_OUT = echo_reg;
  assign REF_BUFFER_ON = refbuf_reg;

  // APB slave
  logic [31:0] status_word;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic slverr_reg;
  logic slverr_next;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`OCR_ST_CONVERTING] = (state_reg != OCR_ACQUIRE);
    status_word[`OCR_ST_DDR] = straps.rate_ddr;
    status_word[`OCR_ST_ECHO_OFF] = straps.echo_off;
    status_word[`OCR_ST_REFBUF] = straps.ref_buf_on;
    status_word[`OCR_ST_IO_LSB +: 2] = straps.io_mode;
    status_word[`OCR_ST_CNT_LSB +: CNT_BITS] = cnt_reg;
  end

  always_comb begin
    // one wait state: the word store answers one cycle after the address is seen
    ack_next = access_cycle & ~ack_reg;
    prdata_next = prdata_reg;
    slverr_next = 1'b0;
    if (access_cycle & ~ack_reg) begin
      slverr_next = ~is_mapped(req.addr) | (req.write & ~is_ch_addr(req.addr));
      if (req.write | ~is_mapped(req.addr)) begin
        prdata_next = 32'h0000_0000;
      end else if (is_ch_addr(req.addr)) begin
        prdata_next = {{(32-RES_BITS){1'b0}}, mem_rd_data};
      end else if (req.addr == `OCR_OFF_STATUS) begin
        prdata_next = status_word;
      end else begin
        prdata_next = conv_count_reg;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ack_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      slverr_reg <= 1'b0;
    end else if (CE) begin
      ack_reg <= ack_next;
      prdata_reg <= prdata_next;
      slverr_reg <= slverr_next;
    end
  end

  assign PREADY = ack_reg & access_cycle;
  assign PSLVERR = slverr_reg & ack_reg & access_cycle;
  assign PRDATA = prdata_reg;
endmodule : ocr_readout

//--- verification/ocr_readout_properties.sv
// concurrent checks on the ports of the octal converter readout block
`timescale 1ns/100ps
`include "ocr_params.svh"
module ocr_readout_properties (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic CONVERT_STROBE_N,
  input wire logic SERIAL_CLOCK,
  input wire logic RATE_SELECT_STRAP,
  input wire logic ECHO_CLOCK_DISABLE_STRAP,
  input wire logic [1:0] IO_STANDARD_STRAP,
  input wire logic REF_BUFFER_ENABLE_STRAP,
  input wire logic [7:0] SERIAL_DATA_OUTPUTS,
  input wire logic [7:0] SERIAL_DATA_OE,
  input wire logic ECHO_CLOCK_OUT,
  input wire logic REF_BUFFER_ON
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  apb_wait_a: assert property (PSEL && PENABLE && !$past(PENABLE) |-> !PREADY ##1 PREADY)
    else $error("ready not after one wait state");
  ready_once_a: assert property (PREADY |=> !PREADY) else $error("ready held too long");
  unmapped_err_a: assert property (PREADY && PADDR > `OCR_OFF_CONV_COUNT |-> PSLVERR && PRDATA == 32'h0000_0000)
    else $error("unmapped access not refused");
  echo_follow_a: assert property ($changed(SERIAL_CLOCK) && !ECHO_CLOCK_DISABLE_STRAP
    |-> ##[1:6] ECHO_CLOCK_OUT == SERIAL_CLOCK) else $error("echo clock does not follow");
  echo_off_a: assert property (ECHO_CLOCK_DISABLE_STRAP [*5] |-> !ECHO_CLOCK_OUT) else $error("echo not off");
  lane_mode_a: assert property ((IO_STANDARD_STRAP != 2'h0) [*5] |-> SERIAL_DATA_OE == 8'h00)
    else $error("lanes driven outside cmos");
  lane_release_a: assert property (CONVERT_STROBE_N [*8] |-> SERIAL_DATA_OE == 8'h00)
    else $error("lanes not released");
  lane_drive_a: assert property ($fell(CONVERT_STROBE_N) && IO_STANDARD_STRAP == 2'h0
    |-> ##[3:7] SERIAL_DATA_OE == 8'hFF) else $error("lanes not driven after strobe");
  sdr_hold_a: assert property (!RATE_SELECT_STRAP && $rose(SERIAL_CLOCK)
    |-> ##2 $stable(SERIAL_DATA_OUTPUTS) [*6]) else $error("data moved on rising edge");
  refbuf_follow_a: assert property ($stable(REF_BUFFER_ENABLE_STRAP) [*6]
    |-> REF_BUFFER_ON == REF_BUFFER_ENABLE_STRAP) else $error("reference buffer state wrong");
endmodule : ocr_readout_properties

bind ocr_readout ocr_readout_properties i_ocr_readout_properties (.REF_CLK, .RST, .PSEL, .PENABLE, .PADDR,
  .PRDATA, .PREADY, .PSLVERR, .CONVERT_STROBE_N, .SERIAL_CLOCK, .RATE_SELECT_STRAP, .ECHO_CLOCK_DISABLE_STRAP,
  .IO_STANDARD_STRAP, .REF_BUFFER_ENABLE_STRAP, .SERIAL_DATA_OUTPUTS, .SERIAL_DATA_OE, .ECHO_CLOCK_OUT,
  .REF_BUFFER_ON);

//--- verification/ocr_host_model.sv
// host side model: drives strobe and serial clock, captures lanes on echo edges
`timescale 1ns/100ps
module ocr_host_model (
  input wire logic clk,
  input wire logic start,
  input wire logic ddr,
  input wire logic [7:0] nper,
  input wire logic [7:0] lanes,
  input wire logic echo,
  output logic strobe_n,
  output logic sclk,
  output logic busy,
  output logic [7:0][127:0] cap
);
  logic echo_q = 1'b0;
  logic [7:0] lanes_q = 8'h00;
  logic clr = 1'b0;
  initial begin
    strobe_n = 1'b1;
    sclk = 1'b0;
    busy = 1'b0;
  end
  // odd offsets keep the link clock unrelated in phase to the system clock
  always @(posedge start) begin
    busy = 1'b1;
    clr = 1'b1;
    #13.7;
    clr = 1'b0;
    strobe_n = 1'b0;
    #120;
    repeat (nper) begin
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
    end
    #40 strobe_n = 1'b1;
    #150 busy = 1'b0;
  end
  // data and echo move at the same edge, so the bit kept is the one seen just before the echo edge
  always @(posedge clk) begin
    echo_q <= echo;
    lanes_q <= lanes;
    if (clr)
      cap <= '0;
    else if (echo !== echo_q && (ddr || echo)) begin
      for (int i = 0; i < 8; i++) cap[i] <= {cap[i][126:0], lanes_q[i]};
    end
  end
endmodule : ocr_host_model

//--- verification/tb_top.sv
// self-checking bench for the octal converter serial readout block
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, start = 1'b0, ph = 1'b0;
  logic rate = 1'b0, echo_dis = 1'b0, refbuf = 1'b1;
  logic [1:0] io = 2'b00;
  logic [7:0] paddr = 8'h00, nper = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, strobe_n, sclk, echo, busy, refon;
  logic [7:0] serial_data_outputs, oe, lanes;
  logic [7:0][127:0] cap;
  logic [15:0] w [8] = '{16'h8000, 16'h7FFF, 16'h1234, 16'hFEDC, 16'h0001, 16'hA5C3, 16'h5A3C, 16'hFFFF};
  int bad_count = 0, n_checks = 0, frames = 0;
  // released lanes toggle so a stale bit cannot pass for data
  assign lanes = (serial_data_outputs & oe) | ({8{ph}} & ~oe);
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) ph <= ~ph;
  ocr_readout i_ocr_readout (.REF_CLK(clk), .RST(rst), .CE(1'b1), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CONVERT_STROBE_N(strobe_n), .SERIAL_CLOCK(sclk), .RATE_SELECT_STRAP(rate), .ECHO_CLOCK_DISABLE_STRAP(echo_dis),
    .IO_STANDARD_STRAP(io), .REF_BUFFER_ENABLE_STRAP(refbuf), .SERIAL_DATA_OUTPUTS(serial_data_outputs), .SERIAL_DATA_OE(oe),
    .ECHO_CLOCK_OUT(echo), .REF_BUFFER_ON(refon));
  ocr_host_model i_ocr_host_model (.clk(clk), .start(start), .ddr(rate), .nper(nper), .lanes(lanes),
    .echo(echo), .strobe_n(strobe_n), .sclk(sclk), .busy(busy), .cap(cap));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
    output logic err);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      stop_test();
    end
    // answer taken and request released at the edge where ready is seen high
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic frame(input logic [7:0] np);
    int i;
    nper <= np;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (i = 0; i < 4000; i++) begin
      @(posedge clk);
      if (busy === 1'b0) break;
    end
    if (i == 4000) begin
      bad_count++;
      stop_test();
    end
    frames++;
  endtask : frame
  task automatic t_regs();
    logic [31:0] rd;
    logic err;
    for (int n = 0; n < 8; n++) apb(1'b1, 8'(4 * n), {16'h0000, w[n]}, rd, err);
    for (int n = 0; n < 8; n++) begin
      apb(1'b0, 8'(4 * n), 32'h0000_0000, rd, err);
      chk("word", rd, {16'h0000, w[n]});
    end
    apb(1'b0, 8'h40, 32'h0000_0000, rd, err);
    chk("unmapped", {rd[30:0], err}, 32'h0000_0001);
    apb(1'b1, 8'h20, 32'h0000_FFFF, rd, err);
    chk("status write", {31'h0, err}, 32'h0000_0001);
    $display("end regs");
  endtask : t_regs
  task automatic t_sdr();
    frame(8'h80);
    for (int i = 0; i < 8; i++)
      for (int k = 0; k < 8; k++) chk("sdr", 32'(cap[i][127 - 16 * k -: 16]), 32'(w[(i + k) % 8]));
    $display("end sdr");
  endtask : t_sdr
  task automatic t_ddr();
    logic [31:0] rd;
    logic err;
    rate <= 1'b1;
    frame(8'h08);
    for (int i = 0; i < 8; i++) chk("ddr", 32'(cap[i][15:0]), 32'(w[i]));
    apb(1'b0, 8'h20, 32'h0000_0000, rd, err);
    chk("rate flag", 32'(rd[1]), 32'h0000_0001);
    rate <= 1'b0;
    $display("end ddr");
  endtask : t_ddr
  task automatic t_echo();
    echo_dis <= 1'b1;
    frame(8'h04);
    chk("echo off", cap[0][31:0], 32'h0000_0000);
    echo_dis <= 1'b0;
    $display("end echo");
  endtask : t_echo
  task automatic t_refbuf();
    refbuf <= 1'b0;
    repeat (6) @(posedge clk);
    chk("refbuf off", {31'h0, refon}, 32'h0000_0000);
    refbuf <= 1'b1;
    repeat (6) @(posedge clk);
    chk("refbuf on", {31'h0, refon}, 32'h0000_0001);
    $display("end refbuf");
  endtask : t_refbuf
  task automatic t_modes();
    logic [31:0] rd;
    logic err;
    for (int m = 1; m < 4; m++) begin
      io <= 2'(m);
      frame(8'h02);
      apb(1'b0, 8'h20, 32'h0000_0000, rd, err);
      chk("io mode", 32'(rd[5:4]), (m == 1) ? 32'h0000_0001 : 32'h0000_0002);
    end
    io <= 2'b00;
    apb(1'b0, 8'h24, 32'h0000_0000, rd, err);
    chk("conversions", rd, 32'(frames));
    $display("end modes");
  endtask : t_modes
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_regs();
    t_sdr();
    t_ddr();
    t_echo();
    t_refbuf();
    t_modes();
    stop_test();
  end
endmodule : tb_top
